// ===== shared/epi_pkg.sv
// Purpose: constants and types for the external pin interrupt unit
// Assumes: 8-bit registers on a 32-bit Avalon-MM slave, one word per register
// Notes:   register byte address is four times the register index
`default_nettype none
package epi_pkg;
    localparam int unsigned ADDR_W        = 9;
    localparam int unsigned DATA_W        = 32;
    localparam int unsigned REG_W         = 8;
    localparam int unsigned PC_LINES      = 16;
    localparam int unsigned GRP_W         = 8;

    // register indices; byte address = index * 4
    localparam logic [7:0] IDX_PC_MASK_LOW  = 8'h6B;
    localparam logic [7:0] IDX_PC_MASK_HIGH = 8'h6C;
    localparam logic [7:0] IDX_SENSE_CTRL   = 8'h69;
    localparam logic [7:0] IDX_EN_MASK      = 8'h3D;
    localparam logic [7:0] IDX_FLAGS        = 8'h3C;
    localparam logic [1:0] IDX_SHIFT        = 2'h2;

    localparam logic [7:0] RST_REG          = 8'h00;

    // bit positions in enable mask and flag registers
    localparam int unsigned BIT_PC_HIGH   = 7;
    localparam int unsigned BIT_PC_LOW    = 6;
    localparam int unsigned BIT_EXT       = 0;
    localparam logic [7:0]  EN_FLAG_MASK  = 8'hC1;
    localparam logic [7:0]  SENSE_MASK    = 8'h03;

    // sense select codes
    localparam logic [1:0] SENSE_LEVEL    = 2'h0;
    localparam logic [1:0] SENSE_CHANGE   = 2'h1;
    localparam logic [1:0] SENSE_FALL     = 2'h2;
    localparam logic [1:0] SENSE_RISE     = 2'h3;

    // vector codes toward the cpu, in priority order
    localparam logic [1:0] VEC_EXT        = 2'h0;
    localparam logic [1:0] VEC_PC_LOW     = 2'h1;
    localparam logic [1:0] VEC_PC_HIGH    = 2'h2;
    localparam logic [1:0] VEC_NONE       = 2'h3;

    typedef enum logic {
        BUS_IDLE = 1'b0,
        BUS_ACK  = 1'b1
    } epi_bus_e;

    typedef struct packed {
        logic       req;
        logic [1:0] vec;
    } epi_irq_s;

    typedef struct packed {
        logic       ack;
        logic [1:0] vec;
    } epi_ack_s;
endpackage : epi_pkg
`default_nettype wire

// ===== logic/epi_top.sv
// Purpose: external pin and pin-change interrupt unit with Avalon-MM registers
// Assumes: pins arrive asynchronously; cpu side runs on core_clk_i
// Notes:   one wait state on every bus access; unmapped reads return zero
//
// Local design decision: register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none
// Contract
// - events seen even when pins drive outputs
// - masked change on lines 15..8 raises high group
// - masked change on lines 7..0 raises low group
// - pin-change detection needs no io clock
// - edge detection only while io clock runs
// - low-level detection needs no io clock
// - level mode requests while pin stays low
// - sense field selects level, change, fall, rise
// - pin sampled first; longer pulses trigger, edges only while io clock runs
// - request needs global enable and source enable
// - enable bits 7, 6, 0 with own vectors
// - flag bits 7, 6, 0 set on trigger
// - flag cleared when its routine is entered
// - writing one clears flag, zero keeps it
// - flag held clear in level mode
// - high mask register, read/write, resets zero
// - low mask register, read/write, resets zero
module epi_top #(
    parameter int unsigned PC_N = epi_pkg::PC_LINES
) (
    input  wire logic                       core_clk_i,
    input  wire logic                       rst_b_i,
    input  wire logic [epi_pkg::ADDR_W-1:0] avs_address_i,
    input  wire logic                       avs_read_i,
    input  wire logic                       avs_write_i,
    input  wire logic [epi_pkg::DATA_W-1:0] avs_writedata_i,
    input  wire logic [3:0]                 avs_byteenable_i,
    output logic      [epi_pkg::DATA_W-1:0] avs_readdata_o,
    output logic                            avs_waitrequest_o,
    input  wire logic                       ext_irq_pin_i,
    input  wire logic [PC_N-1:0]            pin_change_lines_i,
    input  wire logic                       io_clk_run_i,
    input  wire logic                       global_irq_en_i,
    input  wire epi_pkg::epi_ack_s          irq_ack_i,
    output epi_pkg::epi_irq_s               irq_o,
    output logic                            wake_o
);

    // pin synchronisers; the first stage is read only by the second
    logic [PC_N:0] sync1_ff;
    logic [PC_N:0] sync2_ff;
    logic [PC_N:0] prev_ff;
    logic          ext_prev_ff;
    logic [PC_N:0] nxt_sync1;
    logic [PC_N:0] nxt_sync2;
    logic [PC_N:0] nxt_prev;
    logic          nxt_ext_prev;
    logic [2:0]    fill_ff;
    logic [2:0]    nxt_fill;
    logic          primed;

    always_comb begin
        nxt_sync1 = {ext_irq_pin_i, pin_change_lines_i};
        nxt_sync2 = sync1_ff;
        nxt_prev  = sync2_ff;
        // ones walk in behind the pin samples; the flops reset to zero, not to the pins
        nxt_fill  = {fill_ff[1:0], 1'b1};
        // edge history freezes while the io clock is halted
        nxt_ext_prev = (io_clk_run_i || !primed) ? sync2_ff[PC_N] : ext_prev_ff;
    end

    // no compare until prev holds a real sample, else a high pin fakes an edge
    assign primed = fill_ff[2];

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sync1_ff    <= '0;
            sync2_ff    <= '0;
            prev_ff     <= '0;
            ext_prev_ff <= 1'b0;
            fill_ff     <= '0;
        end else begin
            sync1_ff    <= nxt_sync1;
            sync2_ff    <= nxt_sync2;
            prev_ff     <= nxt_prev;
            ext_prev_ff <= nxt_ext_prev;
            fill_ff     <= nxt_fill;
        end
    end

    // registers
    logic [epi_pkg::REG_W-1:0] pc_mask_low_ff;
    logic [epi_pkg::REG_W-1:0] pc_mask_high_ff;
    logic [epi_pkg::REG_W-1:0] sense_ff;
    logic [epi_pkg::REG_W-1:0] en_ff;
    logic [epi_pkg::REG_W-1:0] flags_ff;
    logic [epi_pkg::REG_W-1:0] nxt_pc_mask_low;
    logic [epi_pkg::REG_W-1:0] nxt_pc_mask_high;
    logic [epi_pkg::REG_W-1:0] nxt_sense;
    logic [epi_pkg::REG_W-1:0] nxt_en;
    logic [epi_pkg::REG_W-1:0] nxt_flags;

    // bus handshake
    epi_pkg::epi_bus_e         bus_ff;
    epi_pkg::epi_bus_e         nxt_bus;
    logic [epi_pkg::DATA_W-1:0] rdata_ff;
    logic [epi_pkg::DATA_W-1:0] nxt_rdata;
    logic                      bus_req;
    logic                      wr_go;
    logic                      rd_go;
    logic [7:0]                wbyte;

    function automatic logic hit(input logic [epi_pkg::ADDR_W-1:0] a,
                                 input logic [7:0]                 i);
        hit = (a[1:0] == 2'h0) && (a[epi_pkg::ADDR_W-1:epi_pkg::IDX_SHIFT] == i[6:0]);
    endfunction

    assign bus_req           = avs_read_i | avs_write_i;
    assign avs_waitrequest_o = bus_req && (bus_ff == epi_pkg::BUS_IDLE);
    assign wr_go             = avs_write_i && (bus_ff == epi_pkg::BUS_ACK);
    assign rd_go             = avs_read_i && (bus_ff == epi_pkg::BUS_IDLE);
    assign wbyte             = avs_byteenable_i[0] ? avs_writedata_i[7:0] : 8'h00;
    assign avs_readdata_o    = rdata_ff;

    always_comb begin
        nxt_bus = bus_ff;
        unique case (bus_ff)
            epi_pkg::BUS_IDLE: begin
                if (bus_req) begin
                    nxt_bus = epi_pkg::BUS_ACK;
                end
            end
            epi_pkg::BUS_ACK: begin
                nxt_bus = epi_pkg::BUS_IDLE;
            end
        endcase
    end

    always_comb begin
        nxt_rdata = rdata_ff;
        if (rd_go) begin
            nxt_rdata = '0;
            if (hit(avs_address_i, epi_pkg::IDX_PC_MASK_LOW)) begin
                nxt_rdata[7:0] = pc_mask_low_ff;
            end else if (hit(avs_address_i, epi_pkg::IDX_PC_MASK_HIGH)) begin
                nxt_rdata[7:0] = pc_mask_high_ff;
            end else if (hit(avs_address_i, epi_pkg::IDX_SENSE_CTRL)) begin
                nxt_rdata[7:0] = sense_ff;
            end else if (hit(avs_address_i, epi_pkg::IDX_EN_MASK)) begin
                nxt_rdata[7:0] = en_ff;
            end else if (hit(avs_address_i, epi_pkg::IDX_FLAGS)) begin
                nxt_rdata[7:0] = flags_ff;
            end
        end
    end

    // detection
    logic [1:0] sense;
    logic       ext_now;
    logic       ext_rise;
    logic       ext_fall;
    logic       ext_edge_hit;
    logic       ext_level;
    logic [PC_N-1:0] pc_chg;
    logic [PC_N-1:0] pc_mask;
    logic       pc_low_hit;
    logic       pc_high_hit;

    assign sense    = sense_ff[1:0];
    assign ext_now  = sync2_ff[PC_N];
    assign ext_rise = ext_now & ~ext_prev_ff;
    assign ext_fall = ~ext_now & ext_prev_ff;
    assign ext_level = (sense == epi_pkg::SENSE_LEVEL) && !ext_now && primed;
    assign pc_mask  = {pc_mask_high_ff, pc_mask_low_ff};
    // pin change runs off the synced levels, independent of the io clock
    assign pc_chg   = (sync2_ff[PC_N-1:0] ^ prev_ff[PC_N-1:0]) & pc_mask & {PC_N{primed}};
    assign pc_low_hit  = |pc_chg[epi_pkg::GRP_W-1:0];
    assign pc_high_hit = |pc_chg[PC_N-1:epi_pkg::GRP_W];

    always_comb begin
        ext_edge_hit = 1'b0;
        unique case (sense)
            epi_pkg::SENSE_LEVEL:  ext_edge_hit = 1'b0;
            epi_pkg::SENSE_CHANGE: ext_edge_hit = ext_rise | ext_fall;
            epi_pkg::SENSE_FALL:   ext_edge_hit = ext_fall;
            epi_pkg::SENSE_RISE:   ext_edge_hit = ext_rise;
        endcase
        ext_edge_hit = ext_edge_hit & io_clk_run_i & primed;
    end

    // flags: a set in the same cycle as a clear wins
    logic [7:0] flag_set;
    logic [7:0] flag_clr;

    always_comb begin
        flag_set = 8'h00;
        flag_set[epi_pkg::BIT_EXT]     = ext_edge_hit;
        flag_set[epi_pkg::BIT_PC_LOW]  = pc_low_hit;
        flag_set[epi_pkg::BIT_PC_HIGH] = pc_high_hit;
        flag_clr = 8'h00;
        if (wr_go && hit(avs_address_i, epi_pkg::IDX_FLAGS)) begin
            flag_clr = wbyte & epi_pkg::EN_FLAG_MASK;
        end
        if (irq_ack_i.ack) begin
            unique case (irq_ack_i.vec)
                epi_pkg::VEC_EXT:     flag_clr[epi_pkg::BIT_EXT]     = 1'b1;
                epi_pkg::VEC_PC_LOW:  flag_clr[epi_pkg::BIT_PC_LOW]  = 1'b1;
                epi_pkg::VEC_PC_HIGH: flag_clr[epi_pkg::BIT_PC_HIGH] = 1'b1;
                epi_pkg::VEC_NONE:    flag_clr = flag_clr;
            endcase
        end
        nxt_flags = ((flags_ff & ~flag_clr) | flag_set) & epi_pkg::EN_FLAG_MASK;
        if (nxt_sense[1:0] == epi_pkg::SENSE_LEVEL) begin
            nxt_flags[epi_pkg::BIT_EXT] = 1'b0;
        end
    end

    always_comb begin
        nxt_pc_mask_low  = pc_mask_low_ff;
        nxt_pc_mask_high = pc_mask_high_ff;
        nxt_sense        = sense_ff;
        nxt_en           = en_ff;
        if (wr_go && avs_byteenable_i[0]) begin
            if (hit(avs_address_i, epi_pkg::IDX_PC_MASK_LOW)) begin
                nxt_pc_mask_low = wbyte;
            end
            if (hit(avs_address_i, epi_pkg::IDX_PC_MASK_HIGH)) begin
                nxt_pc_mask_high = wbyte;
            end
            if (hit(avs_address_i, epi_pkg::IDX_SENSE_CTRL)) begin
                nxt_sense = wbyte & epi_pkg::SENSE_MASK;
            end
            if (hit(avs_address_i, epi_pkg::IDX_EN_MASK)) begin
                nxt_en = wbyte & epi_pkg::EN_FLAG_MASK;
            end
        end
    end

    // request toward the cpu
    logic [2:0]        pend;
    epi_pkg::epi_irq_s nxt_irq;
    epi_pkg::epi_irq_s irq_ff;
    logic              nxt_wake;
    logic              wake_ff;

    always_comb begin
        pend[0] = en_ff[epi_pkg::BIT_EXT] &
                  (flags_ff[epi_pkg::BIT_EXT] | ext_level);
        pend[1] = en_ff[epi_pkg::BIT_PC_LOW]  & flags_ff[epi_pkg::BIT_PC_LOW];
        pend[2] = en_ff[epi_pkg::BIT_PC_HIGH] & flags_ff[epi_pkg::BIT_PC_HIGH];
        // wake ignores the global enable so a sleeping core can resume
        nxt_wake    = |pend;
        nxt_irq.req = global_irq_en_i && (|pend);
        if (pend[0]) begin
            nxt_irq.vec = epi_pkg::VEC_EXT;
        end else if (pend[1]) begin
            nxt_irq.vec = epi_pkg::VEC_PC_LOW;
        end else if (pend[2]) begin
            nxt_irq.vec = epi_pkg::VEC_PC_HIGH;
        end else begin
            nxt_irq.vec = epi_pkg::VEC_NONE;
        end
    end

    assign irq_o  = irq_ff;
    assign wake_o = wake_ff;

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            bus_ff          <= epi_pkg::BUS_IDLE;
            rdata_ff        <= '0;
            pc_mask_low_ff  <= epi_pkg::RST_REG;
            pc_mask_high_ff <= epi_pkg::RST_REG;
            sense_ff        <= epi_pkg::RST_REG;
            en_ff           <= epi_pkg::RST_REG;
            flags_ff        <= epi_pkg::RST_REG;
            irq_ff          <= '{req: 1'b0, vec: epi_pkg::VEC_NONE};
            wake_ff         <= 1'b0;
        end else begin
            bus_ff          <= nxt_bus;
            rdata_ff        <= nxt_rdata;
            pc_mask_low_ff  <= nxt_pc_mask_low;
            pc_mask_high_ff <= nxt_pc_mask_high;
            sense_ff        <= nxt_sense;
            en_ff           <= nxt_en;
            flags_ff        <= nxt_flags;
            irq_ff          <= nxt_irq;
            wake_ff         <= nxt_wake;
        end
    end

    // checks
    a_level_flag_clear: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (sense == epi_pkg::SENSE_LEVEL) |-> !flags_ff[epi_pkg::BIT_EXT])
        else $error("ext flag set in level mode");

    a_level_keeps_req: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (ext_level && en_ff[epi_pkg::BIT_EXT] && global_irq_en_i)
        |=> (irq_o.req && irq_o.vec == epi_pkg::VEC_EXT))
        else $error("level low without ext request");

    a_gie_gates_req: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        !global_irq_en_i |=> !irq_o.req)
        else $error("request without global enable");

    a_rise_sets_flag: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (sense == epi_pkg::SENSE_RISE && io_clk_run_i && $past(io_clk_run_i) && primed
         && $rose(ext_now))
        |=> flags_ff[epi_pkg::BIT_EXT])
        else $error("rising edge missed");

    a_no_edge_halted: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (!io_clk_run_i && !flags_ff[epi_pkg::BIT_EXT]) |=> !flags_ff[epi_pkg::BIT_EXT])
        else $error("edge flag set with io clock halted");

    a_pc_low_sets: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        pc_low_hit |=> flags_ff[epi_pkg::BIT_PC_LOW])
        else $error("low group change missed");

    a_pc_high_sets: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        pc_high_hit |=> flags_ff[epi_pkg::BIT_PC_HIGH])
        else $error("high group change missed");

    a_w1c_clears: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (wr_go && hit(avs_address_i, epi_pkg::IDX_FLAGS) && avs_byteenable_i[0]
         && avs_writedata_i[epi_pkg::BIT_PC_LOW] && !pc_low_hit)
        |=> !flags_ff[epi_pkg::BIT_PC_LOW])
        else $error("write one did not clear flag");

    a_ack_clears: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (irq_ack_i.ack && irq_ack_i.vec == epi_pkg::VEC_PC_HIGH && !pc_high_hit)
        |=> !flags_ff[epi_pkg::BIT_PC_HIGH])
        else $error("entry did not clear flag");

    a_prio_order: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (irq_o.req && irq_o.vec == epi_pkg::VEC_PC_HIGH) |-> !$past(pend[1]))
        else $error("high group served before low group");

    a_bus_one_wait: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("waitrequest longer than one cycle");

    a_fall_sets_flag: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (sense == epi_pkg::SENSE_FALL && io_clk_run_i && $past(io_clk_run_i) && primed
         && $fell(ext_now)) |=> flags_ff[epi_pkg::BIT_EXT])
        else $error("falling edge missed");

    a_req_has_vec: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        irq_o.req |-> (irq_o.vec != epi_pkg::VEC_NONE))
        else $error("request without a vector");

    a_mask_low_write: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (wr_go && avs_byteenable_i[0] && hit(avs_address_i, epi_pkg::IDX_PC_MASK_LOW))
        |=> (pc_mask_low_ff == $past(avs_writedata_i[7:0])))
        else $error("low mask write lost");

    a_wake_pending: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (|pend) |=> wake_o)
        else $error("pending source without wake");

endmodule // epi_top
`default_nettype wire

// ===== verification/epi_pin_model.sv
// Purpose: board side of the interrupt pins, driven like the port's own outputs
// Assumes: a level asked for by the bench reaches the pins one edge later
// Notes:   pins are always driven, so no released or floating state is modelled
`timescale 1ns/100ps
`default_nettype none
module epi_pin_model (
    input  wire logic        core_clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        ext_lvl_i,
    input  wire logic [15:0] lines_lvl_i,
    output logic             ext_irq_pin_o,
    output logic      [15:0] pin_change_lines_o
);
    logic        ext_ff;
    logic [15:0] lines_ff;
    // pins act as outputs of the port, still seen by the detector
    // a low level stays until the bench lifts it, many cycles later
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ext_ff   <= 1'b1;
            lines_ff <= 16'h0000;
        end else begin
            ext_ff   <= ext_lvl_i;
            lines_ff <= lines_lvl_i;
        end
    end
    assign ext_irq_pin_o      = ext_ff;
    assign pin_change_lines_o = lines_ff;
endmodule // epi_pin_model
`default_nettype wire

// ===== verification/external_pin_interrupt_unit_test.sv
// Purpose: self-checking bench for the pin interrupt unit over its register bus
// Assumes: one clock of 10 MHz; pins reach the unit through epi_pin_model
// Notes:   pin waits cover two sync stages, compare and request register
`timescale 1ns/100ps
`default_nettype none
module external_pin_interrupt_unit_test;
    logic              core_clk;
    logic              rst_b;
    logic [8:0]        avs_address;
    logic              avs_read;
    logic              avs_write;
    logic [31:0]       avs_writedata;
    logic [31:0]       avs_readdata;
    logic              avs_waitrequest;
    logic              ext_lvl;
    logic [15:0]       lines_lvl;
    logic              ext_pin;
    logic [15:0]       lines;
    logic              io_run;
    logic              gie;
    epi_pkg::epi_ack_s irq_ack;
    epi_pkg::epi_irq_s irq;
    logic              wake;
    int                bad_count;
    int                total_checks;
    int                m;

    epi_pin_model pins_m (.core_clk_i(core_clk), .rst_b_i(rst_b), .ext_lvl_i(ext_lvl),
        .lines_lvl_i(lines_lvl), .ext_irq_pin_o(ext_pin), .pin_change_lines_o(lines));
    epi_top dut (.core_clk_i(core_clk), .rst_b_i(rst_b), .avs_address_i(avs_address),
        .avs_read_i(avs_read), .avs_write_i(avs_write), .avs_writedata_i(avs_writedata),
        .avs_byteenable_i(4'hF), .avs_readdata_o(avs_readdata),
        .avs_waitrequest_o(avs_waitrequest), .ext_irq_pin_i(ext_pin),
        .pin_change_lines_i(lines), .io_clk_run_i(io_run), .global_irq_en_i(gie),
        .irq_ack_i(irq_ack), .irq_o(irq), .wake_o(wake));

    task automatic wrap_up();
        if (bad_count == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // request held until waitrequest is sampled low; one idle edge keeps drives apart
    task automatic bus(input logic [7:0] idx, input logic w, input logic [7:0] d,
                       output logic [31:0] q);
        int n;
        q = 32'h0;
        avs_address   <= 9'({idx, 2'b00});
        avs_writedata <= {24'h000000, d};
        avs_read      <= !w;
        avs_write     <= w;
        for (n = 0; n < 20; n++) begin
            @(posedge core_clk);
            if (avs_waitrequest === 1'b0) break;
        end
        if (n == 20) begin
            bad_count++;
            wrap_up();
        end
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic wr_reg(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] q;
        bus(idx, 1'b1, d, q);
    endtask

    task automatic rd_chk(input string name, input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] q;
        bus(idx, 1'b0, 8'h00, q);
        check(name, q, exp);
    endtask

    task automatic set_pins(input logic e, input logic [15:0] l);
        ext_lvl   <= e;
        lines_lvl <= l;
        repeat (7) @(posedge core_clk);
    endtask

    task automatic irq_chk(input logic r, input logic [1:0] v);
        repeat (2) @(posedge core_clk);
        check("irq_o", {29'h0, irq.req, irq.vec}, {29'h0, r, v});
    endtask

    task automatic send_ack(input logic [1:0] v);
        irq_ack <= '{ack: 1'b1, vec: v};
        @(posedge core_clk);
        irq_ack <= '{ack: 1'b0, vec: epi_pkg::VEC_NONE};
        @(posedge core_clk);
    endtask

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        bad_count++;
        wrap_up();
    end

    initial begin
        bad_count = 0;
        total_checks = 0;
        rst_b = 1'b0;
        avs_address = 9'h000;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        ext_lvl = 1'b1;
        lines_lvl = 16'h0000;
        io_run = 1'b1;
        gie = 1'b1;
        irq_ack = '{ack: 1'b0, vec: epi_pkg::VEC_NONE};
        repeat (3) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        rd_chk("mask_low", epi_pkg::IDX_PC_MASK_LOW, 32'h0);
        rd_chk("mask_high", epi_pkg::IDX_PC_MASK_HIGH, 32'h0);
        rd_chk("flags", epi_pkg::IDX_FLAGS, 32'h0);
        irq_chk(1'b0, epi_pkg::VEC_NONE);
        wr_reg(epi_pkg::IDX_PC_MASK_LOW, 8'hA5);
        rd_chk("mask_low", epi_pkg::IDX_PC_MASK_LOW, 32'hA5);
        wr_reg(epi_pkg::IDX_PC_MASK_HIGH, 8'h5A);
        rd_chk("mask_high", epi_pkg::IDX_PC_MASK_HIGH, 32'h5A);
        wr_reg(8'h10, 8'hFF);
        rd_chk("unmapped", 8'h10, 32'h0);
        wr_reg(epi_pkg::IDX_PC_MASK_LOW, 8'h01);
        wr_reg(epi_pkg::IDX_PC_MASK_HIGH, 8'h01);
        wr_reg(epi_pkg::IDX_SENSE_CTRL, {6'h00, epi_pkg::SENSE_RISE});
        set_pins(1'b1, 16'h0002);
        rd_chk("flags", epi_pkg::IDX_FLAGS, 32'h0);
        set_pins(1'b1, 16'h0003);
        rd_chk("flags", epi_pkg::IDX_FLAGS, 32'h40);
        irq_chk(1'b0, epi_pkg::VEC_NONE);
        wr_reg(epi_pkg::IDX_EN_MASK, 8'h40);
        irq_chk(1'b1, epi_pkg::VEC_PC_LOW);
        gie <= 1'b0;
        irq_chk(1'b0, epi_pkg::VEC_PC_LOW);
        check("wake_o", {31'h0, wake}, 32'h1);
        gie <= 1'b1;
        wr_reg(epi_pkg::IDX_FLAGS, 8'h00);
        rd_chk("flags", epi_pkg::IDX_FLAGS, 32'h40);
        wr_reg(epi_pkg::IDX_FLAGS, 8'h40);
        rd_chk("flags", epi_pkg::IDX_FLAGS, 32'h0);
        wr_reg(epi_pkg::IDX_EN_MASK, 8'hC1);
        set_pins(1'b1, 16'h0103);
        rd_chk("flags", epi_pkg::IDX_FLAGS, 32'h80);
        irq_chk(1'b1, epi_pkg::VEC_PC_HIGH);
        send_ack(epi_pkg::VEC_PC_HIGH);
        rd_chk("flags", epi_pkg::IDX_FLAGS, 32'h0);
        // rise, fall, change: fall then rise, each kept well over one clock
        for (m = 3; m > 0; m--) begin
            wr_reg(epi_pkg::IDX_SENSE_CTRL, 8'(m));
            set_pins(1'b0, 16'h0103);
            rd_chk("ext_fall", epi_pkg::IDX_FLAGS, {31'h0, m != 3});
            wr_reg(epi_pkg::IDX_FLAGS, 8'h01);
            set_pins(1'b1, 16'h0103);
            rd_chk("ext_rise", epi_pkg::IDX_FLAGS, {31'h0, m != 2});
            wr_reg(epi_pkg::IDX_FLAGS, 8'h01);
        end
        set_pins(1'b0, 16'h0102);
        irq_chk(1'b1, epi_pkg::VEC_EXT);
        send_ack(epi_pkg::VEC_EXT);
        irq_chk(1'b1, epi_pkg::VEC_PC_LOW);
        wr_reg(epi_pkg::IDX_FLAGS, 8'h41);
        // io clock stopped: edges ignored, pin changes still seen
        io_run <= 1'b0;
        wr_reg(epi_pkg::IDX_SENSE_CTRL, {6'h00, epi_pkg::SENSE_RISE});
        set_pins(1'b1, 16'h0103);
        rd_chk("flags", epi_pkg::IDX_FLAGS, 32'h40);
        wr_reg(epi_pkg::IDX_FLAGS, 8'h40);
        wr_reg(epi_pkg::IDX_SENSE_CTRL, {6'h00, epi_pkg::SENSE_LEVEL});
        set_pins(1'b0, 16'h0103);
        rd_chk("flags", epi_pkg::IDX_FLAGS, 32'h0);
        irq_chk(1'b1, epi_pkg::VEC_EXT);
        repeat (10) @(posedge core_clk);
        irq_chk(1'b1, epi_pkg::VEC_EXT);
        io_run <= 1'b1;
        set_pins(1'b1, 16'h0103);
        irq_chk(1'b0, epi_pkg::VEC_NONE);
        wrap_up();
    end
endmodule // external_pin_interrupt_unit_test
`default_nettype wire
